// File: rtl/spsp_top.sv
// Purpose: two stepper / pattern shift channels on an 8-bit port, apb slave
// Assumes: timer match strobes and port data arrive from the same clock domain
// Notes: latch nibbles read back as zero; port pins are two signals each

// Contract
// [RL1] two 4-bit channels, per-pin port select
// [RL2] chan0 from 8-bit timer, chan1 selectable
// [RL3] control register selects mode, excitation, direction
// [RL4] pattern mode blocks cpu latch writes
// [RL5] pattern mode shifts like 1-2 step
// [RL6] software refills nibble before next trigger
// [RL7] pattern mode: mode bits 1, dir 0
// [RL8] trigger rising edge shifts latch to pins
// [RL9] direction 0 upward, 1 downward rotation
// [RL10] software seeds one or two ones
// [RL11] 1/2-step ignores alternate nibble
// [RL12] 1-2 step rotates eight-bit ring
// [RL13] software seeds interleaved three ones
// [RL14] latch write-only reset zero, alternate rw
// [RL15] software avoids read-modify-write
// [RL16] shift trigger separate from toggle trigger
// [RL17] ppg mode triggers on cycle match
// [RL18] pwm mode produces no trigger
// [RL19] software enables ff1 toggle
// [RL20] 16-bit triggers on second compare match
// [RL21] software sets timer match enables
// [RL22] software follows setup order
// [RL23] unselected pins keep port behaviour
module spsp_top (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic tmr8_ff_match_i,
    input wire logic tmr8_cyc_match_i,
    input wire logic tmr8_any_match_i,
    input wire logic tmr4_cmp_b_match_i,
    input wire logic tmr5_cmp_b_match_i,
    input wire logic [7:0] port6_out_i,
    input wire logic [7:0] port6_dir_ctrl_i,
    output logic [7:0] port6_pin_o,
    output logic [7:0] port6_pin_oe_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] shift_port_ctrl_reg_r;
    logic [7:0] port6_function_sel_r;
    logic [7:0] trig_cfg_r;
    logic [7:0] pin_r;
    logic [7:0] pin_oe_r;
    logic [31:0] prdata_r;
    logic [1:0] trig_prev_r;
    logic [1:0] trig_cnt0_r;
    logic [1:0] trig_cnt1_r;
    logic [3:0] chan0_latch;
    logic [3:0] chan0_alt_nibble;
    logic [3:0] chan1_latch;
    logic [3:0] chan1_alt;
    logic [7:0] port6_drive;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    localparam int SPSP_ADDR_LSB_W = spsp_pkg::SPSP_ADDR_LSB;
    function automatic logic hit(input logic [31:0] addr, input logic [7:0] idx);
        hit = (addr[31:SPSP_ADDR_LSB_W] == {22'h000000, idx}) && (addr[1:0] == 2'h0);
    endfunction

    wire access = psel_i & penable_i;
    wire wr_en = access & pwrite_i;
    wire hit_ch0 = hit(paddr_i, spsp_pkg::SPSP_IDX_CHAN0);
    wire hit_ch1 = hit(paddr_i, spsp_pkg::SPSP_IDX_CHAN1);
    wire hit_ctrl = hit(paddr_i, spsp_pkg::SPSP_IDX_CTRL);
    wire hit_pfsel = hit(paddr_i, spsp_pkg::SPSP_IDX_PFSEL);
    wire hit_trig = hit(paddr_i, spsp_pkg::SPSP_IDX_TRIG);
    wire hit_stat = hit(paddr_i, spsp_pkg::SPSP_IDX_STAT);
    wire mapped = hit_ch0 | hit_ch1 | hit_ctrl | hit_pfsel | hit_trig | hit_stat;

    // zero-wait slave; unmapped addresses answer with pslverr
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~mapped;
    assign prdata_o = prdata_r;

    // ------------------------------------------------------------
    // control field views
    // ------------------------------------------------------------
    localparam int C1 = spsp_pkg::SPSP_CTRL_CH1_LSB;
    wire chan0_pattern_sel = shift_port_ctrl_reg_r[spsp_pkg::SPSP_CTRL_PAT_BIT]; // [RL3]
    wire chan0_dir = shift_port_ctrl_reg_r[spsp_pkg::SPSP_CTRL_DIR_BIT];
    wire chan0_mode_sel = shift_port_ctrl_reg_r[spsp_pkg::SPSP_CTRL_MODE_BIT];
    wire chan1_pattern_sel = shift_port_ctrl_reg_r[C1 + spsp_pkg::SPSP_CTRL_PAT_BIT];
    wire chan1_dir = shift_port_ctrl_reg_r[C1 + spsp_pkg::SPSP_CTRL_DIR_BIT];
    wire chan1_mode_sel = shift_port_ctrl_reg_r[C1 + spsp_pkg::SPSP_CTRL_MODE_BIT];

    // ------------------------------------------------------------
    // shift trigger sources
    // ------------------------------------------------------------
    // the shift trigger is its own condition, not the ff toggle strobe
    wire t8_ppg = trig_cfg_r[spsp_pkg::SPSP_TRIG_T8_PPG];
    wire t8_pwm = trig_cfg_r[spsp_pkg::SPSP_TRIG_T8_PWM];
    wire tmr8_ff1_toggle_en = trig_cfg_r[spsp_pkg::SPSP_TRIG_T8_TEN];
    wire t8_src = t8_ppg ? tmr8_cyc_match_i : tmr8_any_match_i; // [RL16] [RL17]
    wire t8_level = tmr8_ff1_toggle_en & ~t8_pwm & t8_src; // [RL18]
    wire tmr4_match_trig_en = trig_cfg_r[spsp_pkg::SPSP_TRIG_T4_EN_A];
    wire tmr4_match_trig_en_alt = trig_cfg_r[spsp_pkg::SPSP_TRIG_T4_EN_B];
    wire tmr5_match_trig_en = trig_cfg_r[spsp_pkg::SPSP_TRIG_T5_EN];
    // [RL20]
    wire t4_level = (tmr4_match_trig_en | tmr4_match_trig_en_alt) & tmr4_cmp_b_match_i;
    wire t5_level = tmr5_match_trig_en & tmr5_cmp_b_match_i; // [RL20]
    wire t16_level = trig_cfg_r[spsp_pkg::SPSP_TRIG_CH1_SRC] ? t5_level : t4_level;
    wire ch1_level = trig_cfg_r[spsp_pkg::SPSP_TRIG_CH1_T16] ? t16_level : t8_level; // [RL2]
    // rising edge only: a held match yields one shift
    wire ch0_trig = t8_level & ~trig_prev_r[0]; // [RL8] [RL2]
    wire ch1_trig = ch1_level & ~trig_prev_r[1]; // [RL8]

    // trigger edge memory
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            trig_prev_r <= 2'h0;
        end else begin
            trig_prev_r <= {ch1_level, t8_level};
        end
    end

    // wrap-around shift counters, visible to software for refill pacing
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            trig_cnt0_r <= 2'h0;
            trig_cnt1_r <= 2'h0;
        end else begin
            trig_cnt0_r <= trig_cnt0_r + {1'b0, ch0_trig};
            trig_cnt1_r <= trig_cnt1_r + {1'b0, ch1_trig};
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            shift_port_ctrl_reg_r <= spsp_pkg::SPSP_CTRL_RST;
            port6_function_sel_r <= spsp_pkg::SPSP_PFSEL_RST;
            trig_cfg_r <= spsp_pkg::SPSP_TRIG_RST;
        end else begin
            if (wr_en && hit_ctrl) begin
                shift_port_ctrl_reg_r <= pwdata_i[7:0]; // [RL3]
            end
            if (wr_en && hit_pfsel) begin
                port6_function_sel_r <= pwdata_i[7:0]; // [RL1]
            end
            if (wr_en && hit_trig) begin
                trig_cfg_r <= pwdata_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    spsp_chan u_shift_chan0 (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .trig_i(ch0_trig),
        .pat_sel_i(chan0_pattern_sel),
        .dir_i(chan0_dir),
        .mode_sel_i(chan0_mode_sel),
        .wr_i(wr_en & hit_ch0),
        .wdata_i(pwdata_i[7:0]),
        .latch_o(chan0_latch),
        .alt_o(chan0_alt_nibble)
    );

    spsp_chan u_shift_chan1 (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .trig_i(ch1_trig),
        .pat_sel_i(chan1_pattern_sel),
        .dir_i(chan1_dir),
        .mode_sel_i(chan1_mode_sel),
        .wr_i(wr_en & hit_ch1),
        .wdata_i(pwdata_i[7:0]),
        .latch_o(chan1_latch),
        .alt_o(chan1_alt)
    );

    // ------------------------------------------------------------
    // port 6 pins
    // ------------------------------------------------------------
    // per-pin choice between port data and channel output
    assign port6_drive = (port6_function_sel_r & {chan1_latch, chan0_latch})
                       | (~port6_function_sel_r & port6_out_i); // [RL1] [RL23]

    // pins registered so data outputs come from flip-flops
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            pin_r <= 8'h00;
            pin_oe_r <= 8'h00;
        end else begin
            pin_r <= port6_drive; // [RL8]
            pin_oe_r <= port6_dir_ctrl_i;
        end
    end
    assign port6_pin_o = pin_r;
    assign port6_pin_oe_o = pin_oe_r;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // latch nibbles read as zero: they are write-only
    assign rd_mux = hit_ch0 ? {28'h0000000, chan0_alt_nibble} // [RL14]
                  : hit_ch1 ? {28'h0000000, chan1_alt}
                  : hit_ctrl ? {24'h000000, shift_port_ctrl_reg_r}
                  : hit_pfsel ? {24'h000000, port6_function_sel_r}
                  : hit_trig ? {24'h000000, trig_cfg_r}
                  : hit_stat ? {24'h000000, trig_cnt1_r, trig_cnt0_r, 4'h0}
                  : 32'h00000000;

    // read data captured in setup so it is stable in the access phase
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            prdata_r <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_r <= rd_mux;
        end
    end
endmodule // spsp_top

// File: rtl/spsp_pkg.sv
// Purpose: shared constants for the stepper pattern shift port
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: offsets of all six registers are indices, byte address is four times
package spsp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] SPSP_IDX_CHAN0 = 8'h4c;
    localparam logic [7:0] SPSP_IDX_CHAN1 = 8'h4d;
    localparam logic [7:0] SPSP_IDX_CTRL = 8'h4e;
    localparam logic [7:0] SPSP_IDX_PFSEL = 8'h4f;
    localparam logic [7:0] SPSP_IDX_TRIG = 8'h50;
    localparam logic [7:0] SPSP_IDX_STAT = 8'h51;
    localparam int SPSP_ADDR_LSB = 2;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SPSP_LATCH_LSB = 4;
    localparam int SPSP_CTRL_CH1_LSB = 4;
    localparam int SPSP_CTRL_PAT_BIT = 0;
    localparam int SPSP_CTRL_DIR_BIT = 1;
    localparam int SPSP_CTRL_MODE_BIT = 2;
    localparam int SPSP_TRIG_T8_PPG = 0;
    localparam int SPSP_TRIG_T8_PWM = 1;
    localparam int SPSP_TRIG_T8_TEN = 2;
    localparam int SPSP_TRIG_T4_EN_A = 3;
    localparam int SPSP_TRIG_T4_EN_B = 4;
    localparam int SPSP_TRIG_T5_EN = 5;
    localparam int SPSP_TRIG_CH1_SRC = 6;
    localparam int SPSP_TRIG_CH1_T16 = 7;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SPSP_LATCH_RST = 4'h0;
    localparam logic [3:0] SPSP_ALT_RST = 4'h0;
    localparam logic [7:0] SPSP_CTRL_RST = 8'h00;
    localparam logic [7:0] SPSP_PFSEL_RST = 8'h00;
    localparam logic [7:0] SPSP_TRIG_RST = 8'h00;
    // ------------------------------------------------------------
    // channel step kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SPSP_STEP_HOLD,
        SPSP_STEP_RING4,
        SPSP_STEP_RING8
    } spsp_step_t;
endpackage

// File: rtl/spsp_chan.sv
// Purpose: one 4-bit shift channel with its alternate nibble
// Assumes: trig_i is a one-cycle pulse on clock_i
// Notes: latch bits are write-only, alternate nibble is readable
module spsp_chan (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic trig_i,
    input wire logic pat_sel_i,
    input wire logic dir_i,
    input wire logic mode_sel_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [3:0] latch_o,
    output logic [3:0] alt_o
);
    logic [3:0] latch_r;
    logic [3:0] alt_r;
    logic [3:0] latch_nxt;
    logic [3:0] alt_nxt;
    logic [7:0] ring;
    logic [7:0] ring_fwd;
    logic [7:0] ring_rev;
    logic [3:0] r4_fwd;
    logic [3:0] r4_rev;
    wire pg_mode = mode_sel_i & pat_sel_i;
    wire ring8 = pat_sel_i;

    // ------------------------------------------------------------
    // shift paths
    // ------------------------------------------------------------
    // interleaved ring order l3 a3 l2 a2 l1 a1 l0 a0, ring bit 7 is l3
    assign ring = {latch_r[3], alt_r[3], latch_r[2], alt_r[2],
                   latch_r[1], alt_r[1], latch_r[0], alt_r[0]};
    assign ring_fwd = {ring[6:0], ring[7]}; // [RL9]
    assign ring_rev = {ring[0], ring[7:1]}; // [RL9]
    assign r4_fwd = {latch_r[2:0], latch_r[3]}; // [RL9]
    assign r4_rev = {latch_r[0], latch_r[3:1]}; // [RL9]

    // next value: a trigger wins over a same-cycle cpu write
    always_comb begin
        latch_nxt = latch_r;
        alt_nxt = alt_r;
        if (trig_i) begin
            if (ring8) begin
                // [RL12] [RL5]
                latch_nxt = dir_i ? {ring_rev[7], ring_rev[5], ring_rev[3], ring_rev[1]}
                                  : {ring_fwd[7], ring_fwd[5], ring_fwd[3], ring_fwd[1]};
                alt_nxt = dir_i ? {ring_rev[6], ring_rev[4], ring_rev[2], ring_rev[0]}
                                : {ring_fwd[6], ring_fwd[4], ring_fwd[2], ring_fwd[0]};
            end else begin
                latch_nxt = dir_i ? r4_rev : r4_fwd; // [RL8] [RL11]
            end
        end else if (wr_i) begin
            alt_nxt = wdata_i[3:0];
            if (!pg_mode) begin
                latch_nxt = wdata_i[7:spsp_pkg::SPSP_LATCH_LSB]; // [RL4]
            end
        end
    end

    // state update
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            latch_r <= spsp_pkg::SPSP_LATCH_RST; // [RL14]
            alt_r <= spsp_pkg::SPSP_ALT_RST;
        end else begin
            latch_r <= latch_nxt;
            alt_r <= alt_nxt;
        end
    end

    assign latch_o = latch_r;
    assign alt_o = alt_r;
endmodule // spsp_chan

// File: test/spsp_checker.sv
// Purpose: port-level assertions for spsp_top
// Assumes: one clock, synchronous active-low reset
// Notes: shadows pin-select and control writes so mode-dependent checks know the setup
module spsp_checker (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic tmr8_cyc_match_i,
    input wire logic tmr8_any_match_i,
    input wire logic tmr4_cmp_b_match_i,
    input wire logic tmr5_cmp_b_match_i,
    input wire logic [7:0] port6_out_i,
    input wire logic [7:0] port6_dir_ctrl_i,
    input wire logic [7:0] port6_pin_o,
    input wire logic [7:0] port6_pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic [7:0] pf_r;
    logic [7:0] cr_r;
    logic wr;
    logic trg;
    logic wr0;
    // any trigger level high may shift, so latch checks need all of them low
    assign wr = psel_i && penable_i && pwrite_i && pready_o;
    assign trg = tmr8_cyc_match_i | tmr8_any_match_i | tmr4_cmp_b_match_i | tmr5_cmp_b_match_i;
    assign wr0 = wr && paddr_i == {22'h0, spsp_pkg::SPSP_IDX_CHAN0, 2'b00} && !trg
        && pf_r[3:0] == 4'hf;
    // shadow copies of pin select and control
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            pf_r <= 8'h00;
            cr_r <= 8'h00;
        end else if (wr && paddr_i == {22'h0, spsp_pkg::SPSP_IDX_PFSEL, 2'b00}) begin
            pf_r <= pwdata_i[7:0];
        end else if (wr && paddr_i == {22'h0, spsp_pkg::SPSP_IDX_CTRL, 2'b00}) begin
            cr_r <= pwdata_i[7:0];
        end
    end
    AST_ERR_PHASE: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("error response outside access phase");
    AST_ERR_MAP: assert property (psel_i && penable_i
        && paddr_i[9:2] > spsp_pkg::SPSP_IDX_STAT |-> pslverr_o)
        else $error("unmapped access not flagged");
    AST_ERR_RD0: assert property (psel_i && penable_i && !pwrite_i && pslverr_o
        |-> prdata_o == 32'h0) else $error("unmapped read data not zero");
    AST_RST_PINS: assert property ($rose(rstn_i) |-> port6_pin_o == 8'h00
        && port6_pin_oe_o == 8'h00) else $error("pins not cleared by reset");
    AST_PORT_PASS: assert property ($past(rstn_i) |->
        ((port6_pin_o ^ $past(port6_out_i)) & ~$past(pf_r)) == 8'h00)
        else $error("unselected pin lost port data");
    AST_OE: assert property ($past(rstn_i) |-> port6_pin_oe_o == $past(port6_dir_ctrl_i))
        else $error("pin enable not following direction");
    AST_QUIET: assert property ($past(!wr && !trg) && $past(rstn_i)
        && $stable(port6_out_i) |=> $stable(port6_pin_o)) else $error("pins moved without cause");
    AST_WR_LATCH: assert property (wr0 && !cr_r[2]
        |=> ##1 port6_pin_o[3:0] == $past(pwdata_i[7:4], 2)) else $error("latch write not on pins");
    AST_PAT_BLOCK: assert property (wr0 && cr_r[2:0] == 3'b101
        |=> ##1 $stable(port6_pin_o[3:0])) else $error("latch written in pattern mode");
    cover property (wr0 && cr_r[2:0] == 3'b101);
    cover property (tmr4_cmp_b_match_i && pf_r[7:4] == 4'hf);
    cover property (pslverr_o && !pwrite_i);
endmodule // spsp_checker

bind spsp_top spsp_checker u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tmr8_cyc_match_i(tmr8_cyc_match_i), .tmr8_any_match_i(tmr8_any_match_i),
    .tmr4_cmp_b_match_i(tmr4_cmp_b_match_i), .tmr5_cmp_b_match_i(tmr5_cmp_b_match_i),
    .port6_out_i(port6_out_i), .port6_dir_ctrl_i(port6_dir_ctrl_i),
    .port6_pin_o(port6_pin_o), .port6_pin_oe_o(port6_pin_oe_o));

// File: test/spsp_motor_model.sv
// Purpose: motor driver seen from the phase pins
// Assumes: phases sampled on the system clock
// Notes: no pulls on the phase lines, so a released pin shows the inverse of its last level
module spsp_motor_model (
    input wire logic clock_i,
    input wire logic [7:0] pin_i,
    input wire logic [7:0] oe_i,
    output logic [7:0] phase_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // driven phases are taken as they are, undriven ones never pass for a held level
    always_ff @(posedge clock_i) begin
        phase_o <= (pin_i & oe_i) | (~phase_o & ~oe_i);
    end
endmodule // spsp_motor_model

// File: test/stepper_pattern_shift_port_tb.sv
// Purpose: self-checking bench for spsp_top
// Assumes: zero-wait apb slave, trigger levels from the bench
// Notes: expected pins come from a bench model of both channel rings
module stepper_pattern_shift_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [31:0] paddr_i = 32'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [4:0] tg = 5'h00; // toggle, tmr5, tmr4, cycle, any
    logic [7:0] pout = 8'h00;
    logic [7:0] pdir = 8'hff;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [7:0] pin_o;
    logic [7:0] oe_o;
    logic pin_chk = 1'b0;
    logic [31:0] rq[$];
    logic [7:0] pq[$];
    logic [3:0] lt[2] = '{4'h0, 4'h0};
    logic [3:0] al[2] = '{4'h0, 4'h0};
    logic [1:0] sc[2] = '{2'h0, 2'h0}; // shifts per channel, wraps like the status field
    logic [7:0] ph;
    logic ph_chk = 1'b0;
    logic [7:0] pf = 8'h00;
    logic [7:0] cr = 8'h00;
    logic [7:0] md[4] = '{8'h00, 8'h02, 8'h01, 8'h03};
    logic [7:0] sd[4] = '{8'h10, 8'h30, 8'hc8, 8'h37};
    int bad_count = 0;
    int num_checks = 0;
    spsp_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .tmr8_ff_match_i(tg[4]),
        .tmr8_cyc_match_i(tg[1]), .tmr8_any_match_i(tg[0]), .tmr4_cmp_b_match_i(tg[2]),
        .tmr5_cmp_b_match_i(tg[3]), .port6_out_i(pout), .port6_dir_ctrl_i(pdir),
        .port6_pin_o(pin_o), .port6_pin_oe_o(oe_o));
    spsp_motor_model motor (.clock_i(clock_i), .pin_i(pin_o), .oe_i(oe_o), .phase_o(ph));
    initial forever #4 clock_i = ~clock_i;
    // ----------------------------------------
    // checking and reporting
    // ----------------------------------------
    task automatic miss(input logic [31:0] got, input logic [31:0] exp);
        bad_count++;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) miss(got, exp);
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) miss({24'h0, got}, {24'h0, exp});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // results are taken off the queues as they show at the ports
    always @(posedge clock_i) begin
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
            chk_rd(prdata_o, rq.pop_front());
        end
        if (pin_chk) chk_pin(pin_o, pq.pop_front());
        // only driven phases are compared: released ones toggle in the motor model
        if (ph_chk) chk_pin(ph & pdir, pq.pop_front());
    end
    // ----------------------------------------
    // drivers and channel model
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
        input logic [31:0] exp);
        int n;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= {22'h0, idx, 2'b00};
        pwdata_i <= {24'h0, d};
        if (!w) rq.push_back(exp);
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count++;
            final_report();
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic wch(input int c, input logic [7:0] d);
        apb(1'b1, c ? spsp_pkg::SPSP_IDX_CHAN1 : spsp_pkg::SPSP_IDX_CHAN0, d, 32'h0);
        if (cr[4*c+2] !== 1'b1 || cr[4*c] !== 1'b1) lt[c] = d[7:4];
        al[c] = d[3:0];
    endtask
    function automatic logic [7:0] step(input logic [3:0] l, input logic [3:0] a,
        input logic ring, input logic d);
        logic [7:0] r;
        r = {l[3], a[3], l[2], a[2], l[1], a[1], l[0], a[0]};
        if (!ring) return d ? {l[0], l[3:1], a} : {l[2:0], l[3], a};
        r = d ? {r[0], r[7:1]} : {r[6:0], r[7]};
        return {r[7], r[5], r[3], r[1], r[6], r[4], r[2], r[0]};
    endfunction
    // one-cycle trigger level; go says whether channel c must move
    task automatic pulse(input logic [4:0] m, input int c, input logic go);
        logic [7:0] v;
        tg <= m;
        @(posedge clock_i);
        tg <= 5'h00;
        @(posedge clock_i);
        v = step(lt[c], al[c], cr[4*c], cr[4*c+1]);
        if (go) begin
            {lt[c], al[c]} = v;
            sc[c]++;
        end
        @(posedge clock_i);
    endtask
    task automatic pins();
        pout <= 8'($urandom);
        pdir <= 8'($urandom);
        repeat (2) @(posedge clock_i);
        pq.push_back((pout & ~pf) | ({lt[1], lt[0]} & pf));
        pin_chk <= 1'b1;
        @(posedge clock_i);
        // the motor latches the driven pins one clock later
        pq.push_back(((pout & ~pf) | ({lt[1], lt[0]} & pf)) & pdir);
        pin_chk <= 1'b0;
        ph_chk <= 1'b1;
        @(posedge clock_i);
        ph_chk <= 1'b0;
    endtask
    task automatic setr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 32'h0);
        if (idx == spsp_pkg::SPSP_IDX_CTRL) cr = d;
        if (idx == spsp_pkg::SPSP_IDX_PFSEL) pf = d;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        final_report();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(65079));
        repeat (8) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        apb(1'b0, spsp_pkg::SPSP_IDX_CTRL, 8'h00, {24'h0, spsp_pkg::SPSP_CTRL_RST});
        apb(1'b0, spsp_pkg::SPSP_IDX_TRIG, 8'h00, {24'h0, spsp_pkg::SPSP_TRIG_RST});
        pins();
        apb(1'b0, 8'h52, 8'h00, 32'h0);
        setr(spsp_pkg::SPSP_IDX_TRIG, 8'h8c);
        setr(spsp_pkg::SPSP_IDX_PFSEL, 8'h0f);
        pins();
        wch(0, 8'ha5);
        apb(1'b0, spsp_pkg::SPSP_IDX_CHAN0, 8'h00, 32'h5);
        for (int i = 0; i < 4; i++) begin
            setr(spsp_pkg::SPSP_IDX_CTRL, md[i]);
            wch(0, sd[i]);
            repeat (1 + $urandom % 9) begin
                pulse(5'h01, 0, 1'b1);
                pins();
            end
        end
        setr(spsp_pkg::SPSP_IDX_CTRL, 8'h05);
        wch(0, 8'h3a);
        pins();
        repeat (3) begin
            pulse(5'h01, 0, 1'b1);
            pins();
            wch(0, 8'($urandom));
        end
        setr(spsp_pkg::SPSP_IDX_CTRL, 8'h00);
        wch(0, 8'h10);
        pulse(5'h10, 0, 1'b0);
        pins();
        setr(spsp_pkg::SPSP_IDX_TRIG, 8'h8d);
        pulse(5'h01, 0, 1'b0);
        pulse(5'h02, 0, 1'b1);
        pins();
        setr(spsp_pkg::SPSP_IDX_TRIG, 8'h8e);
        pulse(5'h01, 0, 1'b0);
        setr(spsp_pkg::SPSP_IDX_TRIG, 8'h88);
        pulse(5'h01, 0, 1'b0);
        pins();
        setr(spsp_pkg::SPSP_IDX_TRIG, 8'h8c);
        setr(spsp_pkg::SPSP_IDX_PFSEL, 8'hff);
        wch(1, 8'h10);
        pulse(5'h04, 1, 1'b1);
        pulse(5'h08, 1, 1'b0);
        pins();
        setr(spsp_pkg::SPSP_IDX_TRIG, 8'he4);
        pulse(5'h08, 1, 1'b1);
        pulse(5'h04, 1, 1'b0);
        pins();
        // second timer-4 enable, then channel 1 on the 8-bit trigger beside channel 0
        setr(spsp_pkg::SPSP_IDX_TRIG, 8'h90);
        pulse(5'h04, 1, 1'b1);
        setr(spsp_pkg::SPSP_IDX_TRIG, 8'h14);
        pulse(5'h04, 1, 1'b0);
        pulse(5'h01, 1, 1'b1);
        {lt[0], al[0]} = step(lt[0], al[0], cr[0], cr[1]);
        sc[0]++;
        pins();
        apb(1'b0, spsp_pkg::SPSP_IDX_STAT, 8'h00, {24'h0, sc[1], sc[0], 4'h0});
        final_report();
    end
endmodule // stepper_pattern_shift_port_tb
